// File: logic/dpsr_top.sv
`timescale 1ns/10ps
`default_nettype none

module dpsr_top (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   // left port pins
   input wire dpsr_pkg::dpsr_pins_s left_pins_in,
   output logic [dpsr_pkg::DATA_W-1:0] left_data_out,
   output logic left_data_oe_out,
   // right port pins
   input wire dpsr_pkg::dpsr_pins_s right_pins_in,
   output logic [dpsr_pkg::DATA_W-1:0] right_data_out,
   output logic right_data_oe_out
);
   import dpsr_pkg::*;

   localparam int VIS_MAX = WRITE_TO_READ_DELAY_CYC;
   localparam int FT_MAX = FLOW_THROUGH_ACCESS_TIME_CYC;

   logic [DATA_W-1:0] mem_q [MEM_DEPTH];
   dpsr_req_s l_req;
   dpsr_req_s r_req;
   logic [DATA_W-1:0] l_rd;
   logic [DATA_W-1:0] r_rd;
   dpsr_top_st_s st_q;
   dpsr_top_st_s st_d;
   logic l_sel;
   logic r_sel;
   logic l_ft_rd;
   logic r_ft_rd;
   logic l_pl_rd;
   logic r_pl_rd;

   // separate counters and pipelines per port
   dpsr_port u_left (
      .sys_clk_in(sys_clk_in),
      .rst_n_in(rst_n_in),
      .pins_in(left_pins_in),
      .rd_data_in(l_rd),
      .req_out(l_req),
      .data_out(left_data_out),
      .data_oe_out(left_data_oe_out)
   );

   dpsr_port u_right (
      .sys_clk_in(sys_clk_in),
      .rst_n_in(rst_n_in),
      .pins_in(right_pins_in),
      .rd_data_in(r_rd),
      .req_out(r_req),
      .data_out(right_data_out),
      .data_oe_out(right_data_oe_out)
   );

   // same-address writes in one cycle: right port wins
   always_ff @(posedge sys_clk_in) begin
      if (l_req.we) begin
         mem_q[l_req.addr] <= l_req.din;
      end
      if (r_req.we) begin
         mem_q[r_req.addr] <= r_req.din;
      end
   end

   // a write lands at the edge, so the other port sees it from the next cycle
   assign l_rd = mem_q[l_req.addr];
   assign r_rd = mem_q[r_req.addr];

   // last-cycle writes of each port, watched by the cross-port checks
   always_comb begin
      st_d = st_q;
      st_d.lw_v = l_req.we;
      st_d.lw_addr = l_req.addr;
      st_d.lw_data = l_req.din;
      st_d.rw_v = r_req.we;
      st_d.rw_addr = r_req.addr;
      st_d.rw_data = r_req.din;
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_q <= '{lw_v: 1'b0, lw_addr: ADDR_RST, lw_data: DATA_RST,
                   rw_v: 1'b0, rw_addr: ADDR_RST, rw_data: DATA_RST};
      end else begin
         st_q <= st_d;
      end
   end

   assign l_sel = !left_pins_in.port_select_active_low && left_pins_in.port_select_active_high;
   assign r_sel = !right_pins_in.port_select_active_low && right_pins_in.port_select_active_high;
   assign l_ft_rd = l_sel && left_pins_in.write_select_n && !left_pins_in.latency_select;
   assign r_ft_rd = r_sel && right_pins_in.write_select_n && !right_pins_in.latency_select;
   assign l_pl_rd = l_sel && left_pins_in.write_select_n && left_pins_in.latency_select;
   assign r_pl_rd = r_sel && right_pins_in.write_select_n && right_pins_in.latency_select;

   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (!rst_n_in);

   property p_oe_async;
      left_pins_in.output_enable_n |-> !left_data_oe_out;
   endproperty
   a_oe_async: assert property (p_oe_async) else $error("left data driven with oe high");

   property p_ft_deselect;
      (!l_sel && !left_pins_in.latency_select) ##1 !left_pins_in.latency_select
         |-> !left_data_oe_out;
   endproperty
   a_ft_deselect: assert property (p_ft_deselect) else $error("ft deselect not hi-z");

   property p_pl_state;
      (!r_sel && right_pins_in.latency_select) ##1 right_pins_in.latency_select
         |=> !right_data_oe_out;
   endproperty
   a_pl_state: assert property (p_pl_state) else $error("pipelined deselect wrong cycle");

   property p_pl_drive;
      (r_pl_rd ##1 right_pins_in.latency_select) ##1
         (right_pins_in.latency_select && !right_pins_in.output_enable_n)
         |-> right_data_oe_out;
   endproperty
   a_pl_drive: assert property (p_pl_drive) else $error("pipelined read not driven");

   property p_load_hold;
      (!left_pins_in.address_load_strobe_n && left_pins_in.counter_clear_n) ##1
         (left_pins_in.address_load_strobe_n && left_pins_in.counter_clear_n &&
          left_pins_in.count_advance_n)
         |-> l_req.addr == $past(left_pins_in.address);
   endproperty
   a_load_hold: assert property (p_load_hold) else $error("loaded address not held");

   property p_clear;
      !right_pins_in.counter_clear_n ##1
         (right_pins_in.address_load_strobe_n && right_pins_in.counter_clear_n &&
          !right_pins_in.count_advance_n)
         |-> r_req.addr == ADDR_STEP;
   endproperty
   a_clear: assert property (p_clear) else $error("clear then advance not at one");

   property p_load_first;
      (!left_pins_in.address_load_strobe_n && left_pins_in.counter_clear_n &&
       !left_pins_in.count_advance_n)
         |-> l_req.addr == left_pins_in.address;
   endproperty
   a_load_first: assert property (p_load_first) else $error("advance beat load");

   property p_r_ft_deselect;
      (!r_sel && !right_pins_in.latency_select) |=> !right_data_oe_out;
   endproperty
   a_r_ft_deselect: assert property (p_r_ft_deselect) else $error("right ft deselect");

   property p_increment;
      ##1 (left_pins_in.address_load_strobe_n && left_pins_in.counter_clear_n &&
           !left_pins_in.count_advance_n)
         |-> l_req.addr == 17'($past(l_req.addr) + ADDR_STEP);
   endproperty
   a_increment: assert property (p_increment) else $error("counter did not advance by one");

   property p_ft_read;
      l_ft_rd ##1 !left_pins_in.latency_select |-> left_data_out === $past(l_rd);
   endproperty
   a_ft_read: assert property (p_ft_read) else $error("flow-through data wrong");

   property p_pl_read;
      r_pl_rd ##1 right_pins_in.latency_select ##1 1'b1
         |-> right_data_out === $past(r_rd, 2);
   endproperty
   a_pl_read: assert property (p_pl_read) else $error("pipelined data not one cycle late");

   property p_l2r;
      (st_q.lw_v && r_ft_rd && r_req.addr == st_q.lw_addr && !r_req.we && !l_req.we &&
       !(st_q.rw_v && st_q.rw_addr == st_q.lw_addr))
         |=> right_data_out == $past(st_q.lw_data);
   endproperty
   a_l2r: assert property (p_l2r) else $error("left write not seen by right read");

   property p_r2l;
      (st_q.rw_v && l_ft_rd && l_req.addr == st_q.rw_addr && !l_req.we && !r_req.we)
         |=> left_data_out == $past(st_q.rw_data);
   endproperty
   a_r2l: assert property (p_r2l) else $error("right write not seen by left read");

   property p_ft_access;
      (l_ft_rd && !left_pins_in.output_enable_n) ##1
         (!left_pins_in.latency_select && !left_pins_in.output_enable_n)[*1]
         |-> ##[0:FT_MAX] left_data_oe_out;
   endproperty
   a_ft_access: assert property (p_ft_access) else $error("ft read not driven in time");

   property p_indep;
      (left_pins_in.address_load_strobe_n && left_pins_in.counter_clear_n &&
       left_pins_in.count_advance_n) ##1
         (left_pins_in.address_load_strobe_n && left_pins_in.counter_clear_n &&
          left_pins_in.count_advance_n)
         |-> $stable(l_req.addr);
   endproperty
   a_indep: assert property (p_indep) else $error("left counter moved while holding");

   property p_vis_bound;
      (st_q.lw_v && r_ft_rd && r_req.addr == st_q.lw_addr && !r_req.we && !l_req.we &&
       !(st_q.rw_v && st_q.rw_addr == st_q.lw_addr))
         |-> ##[1:VIS_MAX] right_data_out == $past(st_q.lw_data);
   endproperty
   a_vis_bound: assert property (p_vis_bound) else $error("cross data late");

   c_ft_read: cover property (l_ft_rd ##1 left_data_oe_out);
   c_pl_read: cover property (r_pl_rd ##2 right_data_oe_out);
   c_cross: cover property (l_req.we ##1 (r_ft_rd && r_req.addr == st_q.lw_addr));
   c_wrap: cover property (l_req.addr == 17'h1FFFF && !left_pins_in.count_advance_n
                           ##1 l_req.addr == ADDR_RST);

endmodule

`default_nettype wire

// File: inc/dpsr_pkg.sv
package dpsr_pkg;

   // array shape
   localparam int ADDR_W = 17;
   localparam int DATA_W = 8;
   localparam int MEM_DEPTH = 131072;

   // reset values and counter step
   localparam logic [ADDR_W-1:0] ADDR_RST = 17'h00000;
   localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_STEP = 17'h00001;

   // timing, figures in ns, counts in cycles of sys_clk_in
   localparam int CLK_PERIOD_NS = 4;
   localparam int CLOCK_TO_CLOCK_WINDOW_NS = 10;
   localparam int WRITE_TO_READ_DELAY_NS = 35;
   localparam int FLOW_THROUGH_ACCESS_TIME_NS = 18;
   localparam int CLOCK_TO_CLOCK_WINDOW_CYC = CLOCK_TO_CLOCK_WINDOW_NS / CLK_PERIOD_NS;
   localparam int WRITE_TO_READ_DELAY_CYC = WRITE_TO_READ_DELAY_NS / CLK_PERIOD_NS;
   localparam int FLOW_THROUGH_ACCESS_TIME_CYC = FLOW_THROUGH_ACCESS_TIME_NS / CLK_PERIOD_NS;

   // one port's pins, sampled on the rising edge except output_enable_n
   typedef struct packed {
      logic [ADDR_W-1:0] address;
      logic port_select_active_low;
      logic port_select_active_high;
      logic write_select_n;
      logic [DATA_W-1:0] data_in;
      logic address_load_strobe_n;
      logic count_advance_n;
      logic counter_clear_n;
      logic latency_select;
      logic output_enable_n;
   } dpsr_pins_s;

   // one port's access to the array in the current cycle
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic we;
      logic [DATA_W-1:0] din;
   } dpsr_req_s;

   typedef struct packed {
      logic [ADDR_W-1:0] cnt;
      logic [DATA_W-1:0] stage_data;
      logic stage_drive;
      logic [DATA_W-1:0] out_data;
      logic out_drive;
   } dpsr_port_st_s;

   typedef struct packed {
      logic lw_v;
      logic [ADDR_W-1:0] lw_addr;
      logic [DATA_W-1:0] lw_data;
      logic rw_v;
      logic [ADDR_W-1:0] rw_addr;
      logic [DATA_W-1:0] rw_data;
   } dpsr_top_st_s;

endpackage

// File: logic/dpsr_port.sv
`timescale 1ns/10ps
`default_nettype none

module dpsr_port (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   // port pins and array read data
   input wire dpsr_pkg::dpsr_pins_s pins_in,
   input wire logic [dpsr_pkg::DATA_W-1:0] rd_data_in,
   // array access this cycle
   output dpsr_pkg::dpsr_req_s req_out,
   // data pins
   output logic [dpsr_pkg::DATA_W-1:0] data_out,
   output logic data_oe_out
);
   import dpsr_pkg::*;

   dpsr_port_st_s st_q;
   dpsr_port_st_s st_d;
   logic selected;
   logic reading;

   // clear beats load, load beats advance, else hold
   function automatic logic [ADDR_W-1:0] next_addr(input dpsr_pins_s p,
                                                   input logic [ADDR_W-1:0] cnt);
      logic [ADDR_W-1:0] a;
      a = cnt;
      if (!p.counter_clear_n) begin
         a = ADDR_RST;
      end else if (!p.address_load_strobe_n) begin
         a = p.address;
      end else if (!p.count_advance_n) begin
         a = cnt + ADDR_STEP;
      end
      return a;
   endfunction

   always_comb begin
      selected = !pins_in.port_select_active_low && pins_in.port_select_active_high;
      reading = selected && pins_in.write_select_n;
      st_d = st_q;
      st_d.cnt = next_addr(pins_in, st_q.cnt);
      st_d.stage_data = rd_data_in;
      st_d.stage_drive = reading;
      if (pins_in.latency_select) begin
         st_d.out_data = st_q.stage_data;
         st_d.out_drive = st_q.stage_drive;
      end else begin
         st_d.out_data = rd_data_in;
         st_d.out_drive = reading;
      end
      req_out.addr = st_d.cnt;
      req_out.we = selected && !pins_in.write_select_n;
      req_out.din = pins_in.data_in;
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_q <= '{cnt: ADDR_RST, stage_data: DATA_RST, stage_drive: 1'b0,
                   out_data: DATA_RST, out_drive: 1'b0};
      end else begin
         st_q <= st_d;
      end
   end

   assign data_out = st_q.out_data;
   // output enable pin acts without the clock
   assign data_oe_out = st_q.out_drive && !pins_in.output_enable_n;

endmodule

`default_nettype wire

// File: tb/dpsr_ctrl.sv
`timescale 1ns/10ps
`default_nettype none

module dpsr_ctrl (
   // clock
   input wire logic sys_clk_in,
   // request from bench, pins to port
   input wire dpsr_pkg::dpsr_pins_s req_in,
   output dpsr_pkg::dpsr_pins_s pins_out,
   // data pins seen by controller
   input wire logic [dpsr_pkg::DATA_W-1:0] data_in,
   input wire logic oe_in,
   output logic [dpsr_pkg::DATA_W-1:0] bus_out
);
   import dpsr_pkg::*;
   dpsr_pins_s last_wr = '1;
   dpsr_pins_s nxt;
   logic wr_v = 1'b0;
   logic noop_q = 1'b0;
   logic [DATA_W-1:0] held = 8'h00;
   initial pins_out = '1;
   always @(posedge sys_clk_in) begin
      nxt = (noop_q && wr_v) ? last_wr : req_in;
      noop_q <= req_in.port_select_active_low || !req_in.port_select_active_high;
      if (!nxt.write_select_n && !nxt.address_load_strobe_n && nxt.counter_clear_n &&
          !nxt.port_select_active_low && nxt.port_select_active_high) begin
         last_wr = nxt;
         wr_v <= 1'b1;
      end
      pins_out <= nxt;
      if (oe_in) held <= data_in;
   end
   // released bus shows inverse of last driven value
   assign bus_out = oe_in ? data_in : ~held;
endmodule

`default_nettype wire

// File: tb/tb_dpsr_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_dpsr_top;
   import dpsr_pkg::*;
   logic sys_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   dpsr_pins_s req_l = '1, req_r = '1, pins_l, pins_r;
   logic [DATA_W-1:0] dout_l, dout_r, bus_l, bus_r;
   logic oe_l, oe_r;
   int error_cnt = 0;
   int tests_run = 0;
   integer seed = 32'hADB059B4;
   logic [DATA_W-1:0] mem [int];
   logic [ADDR_W-1:0] cnt [2];
   logic [DATA_W-1:0] st_d [2], ex_d [2];
   bit st_v [2], st_k [2], ex_v [2], ex_k [2];

   always #(CLK_PERIOD_NS / 2) sys_clk_in = ~sys_clk_in;

   dpsr_top DUT (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
      .left_pins_in(pins_l), .left_data_out(dout_l), .left_data_oe_out(oe_l),
      .right_pins_in(pins_r), .right_data_out(dout_r), .right_data_oe_out(oe_r));
   dpsr_ctrl u_ctrl_l (.sys_clk_in(sys_clk_in), .req_in(req_l), .pins_out(pins_l),
      .data_in(dout_l), .oe_in(oe_l), .bus_out(bus_l));
   dpsr_ctrl u_ctrl_r (.sys_clk_in(sys_clk_in), .req_in(req_r), .pins_out(pins_r),
      .data_in(dout_r), .oe_in(oe_r), .bus_out(bus_r));

   function automatic dpsr_pins_s rnd_req(input int lat);
      dpsr_pins_s r;
      r.address = 17'($unsigned($random(seed)) % 16);
      r.port_select_active_low = ($unsigned($random(seed)) % 8) == 0;
      r.port_select_active_high = ($unsigned($random(seed)) % 8) != 0;
      r.write_select_n = 1'($random(seed));
      r.data_in = 8'($random(seed));
      r.address_load_strobe_n = ($unsigned($random(seed)) % 4) == 0;
      r.count_advance_n = 1'($random(seed));
      r.counter_clear_n = ($unsigned($random(seed)) % 8) != 0;
      r.latency_select = (lat == 2) ? 1'($random(seed)) : 1'(lat);
      r.output_enable_n = ($unsigned($random(seed)) % 8) == 0;
      return r;
   endfunction

   always @(posedge sys_clk_in or negedge rst_n_in) begin : model
      dpsr_pins_s p;
      logic [ADDR_W-1:0] a [2];
      bit wr [2];
      bit dv, rk;
      logic [DATA_W-1:0] rd;
      if (!rst_n_in) begin
         for (int i = 0; i < 2; i++) begin
            cnt[i] = ADDR_RST;
            st_v[i] = 0;
            ex_v[i] = 0;
         end
      end else begin
         for (int i = 0; i < 2; i++) begin
            p = i ? pins_r : pins_l;
            if (!p.counter_clear_n) a[i] = ADDR_RST;
            else if (!p.address_load_strobe_n) a[i] = p.address;
            else if (!p.count_advance_n) a[i] = cnt[i] + ADDR_STEP;
            else a[i] = cnt[i];
            cnt[i] = a[i];
            wr[i] = !p.port_select_active_low && p.port_select_active_high && !p.write_select_n;
            dv = !p.port_select_active_low && p.port_select_active_high && p.write_select_n;
            rk = mem.exists(int'(a[i]));
            rd = rk ? mem[int'(a[i])] : DATA_RST;
            if (p.latency_select) begin
               ex_d[i] = st_d[i];
               ex_k[i] = st_k[i];
               ex_v[i] = st_v[i];
            end else begin
               ex_d[i] = rd;
               ex_k[i] = rk;
               ex_v[i] = dv;
            end
            st_d[i] = rd;
            st_k[i] = rk;
            st_v[i] = dv;
         end
         // reads above see old data, right port wins a same-address tie
         if (wr[0]) mem[int'(a[0])] = pins_l.data_in;
         if (wr[1]) mem[int'(a[1])] = pins_r.data_in;
      end
   end

   task automatic check_oe(input logic act, input logic exp);
      tests_run++;
      if (act !== exp) begin
         error_cnt++;
         $display("Error at %0t: drive %0h expected %0h", $time, act, exp);
      end
   endtask

   task automatic check_data(input logic [DATA_W-1:0] act, input logic [DATA_W-1:0] exp);
      tests_run++;
      if (act !== exp) begin
         error_cnt++;
         $display("Error at %0t: data %0h expected %0h", $time, act, exp);
      end
   endtask

   always @(negedge sys_clk_in) begin
      if (rst_n_in) begin
         check_oe(oe_l, ex_v[0] && !pins_l.output_enable_n);
         check_oe(oe_r, ex_v[1] && !pins_r.output_enable_n);
         if (ex_v[0] && !pins_l.output_enable_n && ex_k[0])
            check_data(bus_l, ex_d[0]);
         if (ex_v[1] && !pins_r.output_enable_n && ex_k[1])
            check_data(bus_r, ex_d[1]);
      end
   end

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   initial begin
      repeat (4000) @(posedge sys_clk_in);
      error_cnt++;
      final_report();
   end

   // modes: flow, pipelined, random per cycle, left pipelined right flow
   initial begin
      repeat (2) @(posedge sys_clk_in);
      @(negedge sys_clk_in) rst_n_in = 1'b1;
      for (int m = 0; m < 4; m++) begin
         repeat (400) begin
            @(posedge sys_clk_in);
            req_l <= rnd_req(m == 3 ? 1 : m);
            req_r <= rnd_req(m == 3 ? 0 : m);
         end
         $display("test %0d done, mismatches %0d", m, error_cnt);
      end
      repeat (4) @(posedge sys_clk_in);
      final_report();
   end
endmodule

`default_nettype wire
